// ### rtl/term_pkg.sv
package term_pkg;
  // Terminal and output code widths
  localparam int CODE_W = 8;
  localparam int NUM_IN = 8;
  localparam int FREQ_W = 16;
  localparam int NUM_OUT = 3;
  localparam int FUNC_W = 50;
  // Input function codes
  localparam logic [7:0] IN_UP = 8'h0a;
  localparam logic [7:0] IN_DOWN = 8'h0b;
  localparam logic [7:0] IN_UP2 = 8'h0c;
  localparam logic [7:0] IN_DOWN2 = 8'h0d;
  localparam logic [7:0] IN_RAMP_HOLD = 8'h12;
  localparam logic [7:0] IN_PID_I_RESET = 8'h2f;
  localparam logic [7:0] IN_PID_I_HOLD = 8'h30;
  localparam logic [7:0] IN_PID_SOFT_OFF = 8'h31;
  localparam logic [7:0] IN_PID_CHAR_SW = 8'h32;
  localparam logic [7:0] IN_TIMER = 8'h34;
  localparam logic [7:0] IN_OFFSET_1 = 8'h35;
  localparam logic [7:0] IN_OFFSET_2 = 8'h36;
  localparam logic [7:0] IN_OFFSET_3 = 8'h37;
  localparam logic [7:0] IN_KEB_NO = 8'h39;
  localparam logic [7:0] IN_LOCKOUT = 8'h3c;
  localparam logic [7:0] IN_ANALOG_HOLD = 8'h3d;
  localparam logic [7:0] IN_EXT_SEARCH = 8'h3f;
  localparam logic [7:0] IN_DC_BRAKE = 8'h41;
  localparam logic [7:0] IN_ENABLE = 8'h45;
  // Output code ranges and defaults
  localparam logic [7:0] OUT_FUNC_MAX = 8'h31;
  localparam logic [7:0] OUT_INV_BASE = 8'h64;
  localparam logic [7:0] OUT_INV_MAX = 8'h95;
  localparam logic [7:0] OUT_TIMER = 8'h0f;
  localparam logic [7:0] RELAY1_DEFAULT = 8'h00;
  localparam logic [7:0] RELAY2_DEFAULT = 8'h0b;
  localparam logic [7:0] OPEN_COLL_DEFAULT = 8'h01;
  // Ride-through method select range top
  localparam logic [1:0] KEB_METHOD_MAX = 2'h2;
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int HOLD_SAMPLE_MS = 100;
  localparam int SEARCH_LEAD_MS = 1000;
  localparam int HOLD_SAMPLE_CYC = CLK_HZ / 1000 * HOLD_SAMPLE_MS;
  localparam int SEARCH_LEAD_CYC = CLK_HZ / 1000 * SEARCH_LEAD_MS;

  // Decoded input functions
  typedef struct packed {
    logic pid_i_reset;
    logic pid_i_hold;
    logic pid_soft_off;
    logic pid_char_sw;
    logic timer_in;
    logic [2:0] offset_sel;
    logic keb_active;
    logic lockout_closed;
    logic analog_hold;
    logic ext_search;
    logic dc_brake;
    logic enable_closed;
    logic has_lockout;
    logic has_enable;
    logic has_keb;
  } in_funcs_t;

  // Drive state fields; unused, the output selectors take drive_funcs_in
  typedef struct packed {
    logic running;
    logic zero_speed;
    logic fault;
    logic timer_out;
  } drive_status_t;

  // Enable gate states
  typedef enum logic [2:0] {
    EN_IDLE = 3'b001,
    EN_RUN = 3'b010,
    EN_WAIT_CYCLE = 3'b100
  } en_state_t;
endpackage

// ### rtl/level_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts cycles a level has been high; flags once the count is reached
module level_timer
  import term_pkg::*;
#(
  parameter int COUNT = 10
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Level and result
  input wire logic level_in,
  output logic done_out
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // Saturating count while high, restart on low
  always_comb begin
    next_count = count;
    if (!level_in) begin
      next_count = '0;
    end else if (count != CW'(COUNT)) begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done_out = (count == CW'(COUNT));
endmodule
`default_nettype wire

// ### rtl/out_selector.sv
`timescale 1ns/1ps
`default_nettype none
// One output terminal: code picks a function, hundreds digit inverts
module out_selector
  import term_pkg::*;
(
  // Selection
  input wire logic [CODE_W-1:0] code_in,
  input wire logic [FUNC_W-1:0] funcs_in,
  // Resulting terminal level
  output logic level_out
);
  logic [CODE_W-1:0] idx;
  logic valid;
  logic inv;

  // Codes outside both ranges leave the terminal open
  always_comb begin
    inv = 1'b0;
    valid = 1'b0;
    idx = code_in;
    if (code_in <= OUT_FUNC_MAX) begin
      valid = 1'b1;
    end else if (code_in >= OUT_INV_BASE && code_in <= OUT_INV_MAX) begin
      valid = 1'b1;
      inv = 1'b1;
      idx = code_in - OUT_INV_BASE;
    end
    level_out = valid ? (funcs_in[idx[5:0]] ^ inv) : 1'b0;
  end
endmodule
`default_nettype wire

// ### rtl/terminal_function_selector.sv
// How it works
// R1: Integral reset input closed forces PID integrator to zero.
// R2: Integral hold input closed freezes integrator; opening resumes it; freeze is masked while the reset input is closed.
// R3: Soft-start input closed bypasses PID setpoint ramp time.
// R4: Characteristic switch input selects PID input behaviour by level.
// R5: Each closed offset input adds its stored offset frequency.
// R6: Ride-through input active per wiring sense, method setting zero to two.
// R7: Lockout input open blocks parameter writes except frequency monitor.
// R8: Analog hold input closed 100 ms samples and holds analog command.
// R9: Power loss clears held command and zeroes frequency command.
// R10: Analog hold with ramp hold, up/down, bias or offsets is config error; no bias code is decoded here.
// R11: Search input closed one second before run forces search from command.
// R12: DC brake input brakes motor; run or jog ends braking.
// R13: Enable input open rejects run and shows not-enabled indication.
// R14: Run present when enable closes stays stopped until run recycles.
// R15: Enable opening while running stops by selected stopping method.
// R16: Timer input feeds timer; output code 15 presents timer result.
// R17: Output codes 0-49 direct, 100-149 same function inverted.
// R18: Relay one selection defaults to code 0, during run.
// R19: Relay two selection defaults to code 11, fault.
// R20: Open-collector selection defaults to code 1, zero speed.
// R21: Retained or unassigned codes do nothing and ignore the terminal.
//
// Strobed loading of all three output selections at once was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module terminal_function_selector
  import term_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_SAMPLE_CYC,
  parameter int SEARCH_CYCLES = SEARCH_LEAD_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Terminals and their setting codes
  input wire logic [NUM_IN-1:0] term_closed_in,
  input wire logic [NUM_IN*CODE_W-1:0] term_code_in,
  input wire logic keb_nc_wiring_in,
  input wire logic [1:0] ride_through_method_sel_in,
  // Output selections, loaded by a write strobe
  input wire logic sel_we_in,
  input wire logic [NUM_OUT*CODE_W-1:0] sel_data_in,
  // Drive side
  input wire logic run_cmd_in,
  input wire logic jog_cmd_in,
  input wire logic power_loss_in,
  input wire logic [FREQ_W-1:0] analog_freq_in,
  input wire logic [FREQ_W-1:0] freq_cmd_in,
  input wire logic [3*FREQ_W-1:0] offset_freq_in,
  input wire logic param_wr_req_in,
  input wire logic param_is_monitor_in,
  input wire logic [FUNC_W-1:0] drive_funcs_in,
  input wire logic timer_result_in,
  // PID controls
  output logic pid_i_zero_out,
  output logic pid_i_freeze_out,
  output logic pid_ramp_bypass_out,
  output logic pid_char_alt_out,
  // Frequency and mode controls
  output logic [FREQ_W-1:0] freq_cmd_out,
  output logic keb_active_out,
  output logic [1:0] keb_method_out,
  output logic param_wr_ok_out,
  output logic input_combo_config_error_out,
  output logic force_search_out,
  output logic dc_brake_out,
  output logic run_allow_out,
  output logic stop_by_method_out,
  output logic not_enabled_indication_out,
  output logic timer_in_out,
  // Output terminals and their selections
  output logic [NUM_OUT-1:0] out_term_out,
  output logic [NUM_OUT*CODE_W-1:0] sel_out
);
  in_funcs_t f;
  logic has_hold;
  logic has_conflict;
  logic hold_done;
  logic search_done;
  logic [FREQ_W-1:0] held;
  logic [FREQ_W-1:0] next_held;
  logic held_valid;
  logic next_held_valid;
  logic search_armed;
  logic next_search_armed;
  logic run_d;
  logic brake;
  logic next_brake;
  en_state_t en_state;
  en_state_t next_en_state;
  logic [NUM_OUT*CODE_W-1:0] sel;
  logic [NUM_OUT*CODE_W-1:0] next_sel;
  logic [NUM_OUT-1:0] out_lvl;
  logic [FREQ_W-1:0] freq_sum;
  logic [FUNC_W-1:0] funcs;
  logic combo_err;

  // Decode every terminal; codes not listed fall through, leaving it ignored
  always_comb begin
    f = '0;
    has_hold = 1'b0;
    has_conflict = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      case (term_code_in[i*CODE_W +: CODE_W])
        IN_PID_I_RESET: begin
          f.pid_i_reset |= term_closed_in[i]; // [R1]
        end
        IN_PID_I_HOLD: begin
          f.pid_i_hold |= term_closed_in[i]; // [R2]
        end
        IN_PID_SOFT_OFF: begin
          f.pid_soft_off |= term_closed_in[i]; // [R3]
        end
        IN_PID_CHAR_SW: begin
          f.pid_char_sw |= term_closed_in[i]; // [R4]
        end
        IN_TIMER: begin
          f.timer_in |= term_closed_in[i]; // [R16]
        end
        IN_OFFSET_1: begin
          f.offset_sel[0] |= term_closed_in[i]; // [R5]
          has_conflict = 1'b1;
        end
        IN_OFFSET_2: begin
          f.offset_sel[1] |= term_closed_in[i]; // [R5]
          has_conflict = 1'b1;
        end
        IN_OFFSET_3: begin
          f.offset_sel[2] |= term_closed_in[i]; // [R5]
          has_conflict = 1'b1;
        end
        IN_KEB_NO: begin
          f.has_keb = 1'b1;
          f.keb_active |= term_closed_in[i] ^ keb_nc_wiring_in; // [R6]
        end
        IN_LOCKOUT: begin
          f.has_lockout = 1'b1;
          f.lockout_closed |= term_closed_in[i];
        end
        IN_ANALOG_HOLD: begin
          has_hold = 1'b1;
          f.analog_hold |= term_closed_in[i];
        end
        IN_EXT_SEARCH: begin
          f.ext_search |= term_closed_in[i]; // [R11]
        end
        IN_DC_BRAKE: begin
          f.dc_brake |= term_closed_in[i]; // [R12]
        end
        IN_ENABLE: begin
          f.has_enable = 1'b1;
          f.enable_closed |= term_closed_in[i];
        end
        IN_UP, IN_DOWN, IN_UP2, IN_DOWN2, IN_RAMP_HOLD: begin
          has_conflict = 1'b1; // [R10]
        end
        default: ; // Retained or unknown: no action [R21]
      endcase
    end
  end

  // Closed-time qualifiers for sample-and-hold and external search
  level_timer #(.COUNT(HOLD_CYCLES)) hold_timer (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .level_in(f.analog_hold),
    .done_out(hold_done)
  );

  level_timer #(.COUNT(SEARCH_CYCLES)) search_timer (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .level_in(f.ext_search),
    .done_out(search_done)
  );

  // Held analog level, search arming and brake register
  always_comb begin
    next_held = held;
    next_held_valid = held_valid;
    next_search_armed = search_armed;
    next_brake = brake;
    if (power_loss_in) begin
      next_held = '0; // [R9]
      next_held_valid = 1'b0; // [R9]
    end else if (hold_done && !held_valid) begin
      next_held = analog_freq_in; // [R8]
      next_held_valid = 1'b1; // [R8]
    end
    // Armed only while the input has stood closed one second before run
    if (!run_d) begin
      next_search_armed = search_done; // [R11]
    end
    if (run_cmd_in || jog_cmd_in) begin
      next_brake = 1'b0; // [R12]
    end else if (f.dc_brake) begin
      next_brake = 1'b1; // [R12]
    end else begin
      next_brake = 1'b0;
    end
  end

  // Enable gate: run must be recycled after the enable closes
  always_comb begin
    next_en_state = en_state;
    case (en_state)
      EN_IDLE: begin
        if (f.has_enable && !f.enable_closed) begin
          next_en_state = EN_WAIT_CYCLE; // [R13]
        end else if (run_cmd_in) begin
          next_en_state = EN_RUN;
        end
      end
      EN_RUN: begin
        if (f.has_enable && !f.enable_closed) begin
          next_en_state = EN_WAIT_CYCLE; // [R15]
        end else if (!run_cmd_in) begin
          next_en_state = EN_IDLE;
        end
      end
      EN_WAIT_CYCLE: begin
        if ((!f.has_enable || f.enable_closed) && !run_cmd_in) begin
          next_en_state = EN_IDLE; // [R14]
        end
      end
      default: next_en_state = EN_IDLE;
    endcase
  end

  // Output selection storage, defaults per terminal
  always_comb begin
    next_sel = sel;
    if (sel_we_in) begin
      next_sel = sel_data_in;
    end
  end

  // Frequency command: offsets added, held level replaces analog
  always_comb begin
    freq_sum = held_valid ? held : freq_cmd_in; // [R8]
    for (int k = 0; k < 3; k++) begin
      if (f.offset_sel[k]) begin
        freq_sum = freq_sum + offset_freq_in[k*FREQ_W +: FREQ_W]; // [R5]
      end
    end
    if (power_loss_in) begin
      freq_sum = '0; // [R9]
    end
  end

  // Timer function result drives output code 15
  always_comb begin
    funcs = drive_funcs_in;
    funcs[OUT_TIMER[5:0]] = timer_result_in; // [R16]
  end

  // One selector per output terminal
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    out_selector sel_i (
      .code_in(sel[g*CODE_W +: CODE_W]),
      .funcs_in(funcs),
      .level_out(out_lvl[g])
    ); // [R17]
  end

  // State registers
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      held <= '0;
      held_valid <= 1'b0;
      search_armed <= 1'b0;
      run_d <= 1'b0;
      brake <= 1'b0;
      en_state <= EN_IDLE;
      // Selections come up at their defaults
      sel <= {OPEN_COLL_DEFAULT, RELAY2_DEFAULT, RELAY1_DEFAULT}; // [R18] [R19] [R20]
    end else begin
      held <= next_held;
      held_valid <= next_held_valid;
      search_armed <= next_search_armed;
      run_d <= run_cmd_in;
      brake <= next_brake;
      en_state <= next_en_state;
      sel <= next_sel;
    end
  end

  // Config error when the hold shares terminals with conflicting codes
  assign combo_err = has_hold && has_conflict; // [R10]

  // Registered outputs
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      // Every output low while reset holds
      pid_i_zero_out <= 1'b0;
      pid_i_freeze_out <= 1'b0;
      pid_ramp_bypass_out <= 1'b0;
      pid_char_alt_out <= 1'b0;
      freq_cmd_out <= '0;
      keb_active_out <= 1'b0;
      keb_method_out <= '0;
      param_wr_ok_out <= 1'b0;
      input_combo_config_error_out <= 1'b0;
      force_search_out <= 1'b0;
      dc_brake_out <= 1'b0;
      run_allow_out <= 1'b0;
      stop_by_method_out <= 1'b0;
      not_enabled_indication_out <= 1'b0;
      timer_in_out <= 1'b0;
      out_term_out <= '0;
      sel_out <= '0;
    end else begin
      // PID levels follow their terminals; freeze is masked while reset is closed
      pid_i_zero_out <= f.pid_i_reset; // [R1]
      pid_i_freeze_out <= f.pid_i_hold && !f.pid_i_reset; // [R2]
      pid_ramp_bypass_out <= f.pid_soft_off; // [R3]
      pid_char_alt_out <= f.pid_char_sw; // [R4]

      // Command path and ride-through
      freq_cmd_out <= freq_sum; // [R5] [R9]
      keb_active_out <= f.keb_active; // [R6]
      // Out-of-range method settings fall back to method zero
      keb_method_out <= (ride_through_method_sel_in > KEB_METHOD_MAX) ? 2'h0 : ride_through_method_sel_in; // [R6]

      // Write permission and setup check
      param_wr_ok_out <= param_wr_req_in &&
        (!f.has_lockout || f.lockout_closed || param_is_monitor_in); // [R7]
      input_combo_config_error_out <= combo_err; // [R10]

      // Run path: search, brake, enable gate
      force_search_out <= run_cmd_in && !run_d && search_armed; // [R11]
      dc_brake_out <= next_brake; // [R12]
      run_allow_out <= (next_en_state == EN_RUN); // [R13]
      stop_by_method_out <= (en_state == EN_RUN) && (next_en_state == EN_WAIT_CYCLE); // [R15]
      not_enabled_indication_out <= f.has_enable && !f.enable_closed; // [R13]

      // Timer and output terminals
      timer_in_out <= f.timer_in; // [R16]
      out_term_out <= out_lvl;
      sel_out <= sel;
    end
  end
endmodule
`default_nettype wire

// ### verif/contact_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Contacts and run switch wired to the terminals by an outside controller
module contact_bank
  import term_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // What the controller wants
  input wire logic [NUM_IN-1:0] want_closed_in,
  input wire logic [NUM_IN*CODE_W-1:0] want_code_in,
  input wire logic want_run_in,
  // Terminal levels
  output logic [NUM_IN-1:0] term_closed_out = '0,
  output logic [NUM_IN*CODE_W-1:0] term_code_out = '0,
  output logic run_cmd_out = 1'h0
);
  // Contacts move just after an edge; run is recycled by the controller
  always @(posedge clk_sys_in) begin
    term_closed_out <= want_closed_in;
    term_code_out <= want_code_in;
    run_cmd_out <= want_run_in;
  end
endmodule
`default_nettype wire

// ### verif/terminal_function_selector_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks; decode of terminals redone here
module tfs_props
  import term_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Inputs watched
  input wire logic [NUM_IN-1:0] term_closed_in,
  input wire logic [NUM_IN*CODE_W-1:0] term_code_in,
  input wire logic keb_nc_wiring_in,
  input wire logic run_cmd_in,
  input wire logic jog_cmd_in,
  input wire logic power_loss_in,
  input wire logic param_wr_req_in,
  input wire logic param_is_monitor_in,
  // Outputs watched
  input wire logic pid_i_zero_out,
  input wire logic pid_i_freeze_out,
  input wire logic [FREQ_W-1:0] freq_cmd_out,
  input wire logic keb_active_out,
  input wire logic param_wr_ok_out,
  input wire logic input_combo_config_error_out,
  input wire logic force_search_out,
  input wire logic dc_brake_out,
  input wire logic run_allow_out,
  input wire logic stop_by_method_out,
  input wire logic not_enabled_indication_out
);
  // Some terminal holds code c at level lvl
  function automatic logic hit(logic [7:0] c, logic lvl);
    hit = 1'h0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (term_code_in[i*CODE_W +: CODE_W] == c && term_closed_in[i] == lvl) begin
        hit = 1'h1;
      end
    end
  endfunction
  function automatic logic asg(logic [7:0] c);
    asg = hit(c, 1'h0) || hit(c, 1'h1);
  endfunction
  // Decoded views kept as variables, so assertions see sampled values
  logic i_reset_on, i_hold_on, keb_on, lock_open, en_open, combo_bad;
  always_comb begin
    i_reset_on = hit(IN_PID_I_RESET, 1'h1);
    i_hold_on = hit(IN_PID_I_HOLD, 1'h1);
    keb_on = hit(IN_KEB_NO, !keb_nc_wiring_in);
    lock_open = asg(IN_LOCKOUT) && !hit(IN_LOCKOUT, 1'h1);
    en_open = asg(IN_ENABLE) && !hit(IN_ENABLE, 1'h1);
    combo_bad = asg(IN_ANALOG_HOLD) && (asg(IN_RAMP_HOLD) || asg(IN_UP) || asg(IN_DOWN) || asg(IN_UP2)
      || asg(IN_DOWN2) || asg(IN_OFFSET_1) || asg(IN_OFFSET_2) || asg(IN_OFFSET_3));
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // Pulses stand for exactly one cycle
  sequence s_search_once;
    force_search_out ##1 !force_search_out;
  endsequence
  sequence s_stop_once;
    stop_by_method_out ##1 !stop_by_method_out;
  endsequence
  a_pid_zero: assert property (i_reset_on |=> pid_i_zero_out) else $error("pid zero missing");
  a_pid_freeze: assert property ($past(rst_b_in) |-> pid_i_freeze_out == $past(i_hold_on && !i_reset_on))
    else $error("pid freeze wrong");
  a_keb_sense: assert property ($past(rst_b_in) |-> keb_active_out == $past(keb_on))
    else $error("ride-through level wrong");
  a_lockout_block: assert property (lock_open && param_wr_req_in && !param_is_monitor_in
    |=> !param_wr_ok_out) else $error("locked write allowed");
  a_power_zero: assert property (power_loss_in |=> freq_cmd_out == 16'h0000) else $error("command not zeroed");
  a_combo_error: assert property ($past(rst_b_in) |-> input_combo_config_error_out == $past(combo_bad))
    else $error("combo error wrong");
  a_search_pulse: assert property (force_search_out |-> $past(run_cmd_in) ##0 s_search_once)
    else $error("search pulse wrong");
  a_brake_release: assert property (run_cmd_in || jog_cmd_in |=> !dc_brake_out) else $error("brake held");
  a_enable_gate: assert property (en_open |=> !run_allow_out && not_enabled_indication_out)
    else $error("run allowed while disabled");
  a_stop_pulse: assert property (stop_by_method_out |-> $past(en_open) ##0 s_stop_once)
    else $error("stop pulse wrong");
endmodule
bind terminal_function_selector tfs_props u_props (.clk_sys_in, .rst_b_in, .term_closed_in, .term_code_in,
  .keb_nc_wiring_in, .run_cmd_in, .jog_cmd_in, .power_loss_in, .param_wr_req_in, .param_is_monitor_in,
  .pid_i_zero_out, .pid_i_freeze_out, .freq_cmd_out, .keb_active_out, .param_wr_ok_out,
  .input_combo_config_error_out, .force_search_out, .dc_brake_out, .run_allow_out, .stop_by_method_out,
  .not_enabled_indication_out);
`default_nettype wire

// ### verif/terminal_function_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none
module terminal_function_selector_tb;
  import term_pkg::*;
  // Short counts keep the run brief
  localparam int HOLD_N = 20;
  localparam int SEARCH_N = 50;
  logic clk_sys_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic [NUM_IN-1:0] want_closed = '0;
  logic [NUM_IN*CODE_W-1:0] want_code = '0;
  logic want_run = 1'h0;
  logic [NUM_IN-1:0] term_closed;
  logic [NUM_IN*CODE_W-1:0] term_code;
  logic run_cmd;
  logic keb_nc = 1'h0, sel_we = 1'h0, jog = 1'h0, power_loss = 1'h0, wr_req = 1'h0, is_mon = 1'h0;
  logic timer_res = 1'h0;
  logic [1:0] method = 2'h0;
  logic [23:0] sel_data = '0;
  logic [15:0] analog = '0, freq_cmd = '0;
  logic [47:0] offsets = {16'h0030, 16'h0020, 16'h0010};
  logic [FUNC_W-1:0] funcs = '0;
  logic pid_zero, pid_freeze, pid_bypass, pid_alt, keb_act, wr_ok, cfg_err, search, brake, run_ok;
  logic stop_pulse, not_enabled_indication, timer_fwd;
  logic [1:0] keb_meth;
  logic [15:0] freq_out;
  logic [2:0] out_term;
  logic [23:0] sel_now;
  logic seen;
  int n_errors = 0;
  int n_checks = 0;
  logic [7:0] combo[8] = '{IN_RAMP_HOLD, IN_UP, IN_DOWN, IN_UP2, IN_DOWN2, IN_OFFSET_1, IN_OFFSET_2, IN_OFFSET_3};

  // 100 MHz clock
  always #5 clk_sys_in = ~clk_sys_in;

  contact_bank bank (.clk_sys_in(clk_sys_in), .want_closed_in(want_closed), .want_code_in(want_code),
    .want_run_in(want_run), .term_closed_out(term_closed), .term_code_out(term_code), .run_cmd_out(run_cmd));

  terminal_function_selector #(.HOLD_CYCLES(HOLD_N), .SEARCH_CYCLES(SEARCH_N)) uut (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .term_closed_in(term_closed), .term_code_in(term_code), .keb_nc_wiring_in(keb_nc),
    .ride_through_method_sel_in(method), .sel_we_in(sel_we), .sel_data_in(sel_data), .run_cmd_in(run_cmd),
    .jog_cmd_in(jog), .power_loss_in(power_loss), .analog_freq_in(analog), .freq_cmd_in(freq_cmd),
    .offset_freq_in(offsets), .param_wr_req_in(wr_req), .param_is_monitor_in(is_mon), .drive_funcs_in(funcs),
    .timer_result_in(timer_res), .pid_i_zero_out(pid_zero), .pid_i_freeze_out(pid_freeze),
    .pid_ramp_bypass_out(pid_bypass), .pid_char_alt_out(pid_alt), .freq_cmd_out(freq_out),
    .keb_active_out(keb_act), .keb_method_out(keb_meth), .param_wr_ok_out(wr_ok),
    .input_combo_config_error_out(cfg_err), .force_search_out(search), .dc_brake_out(brake),
    .run_allow_out(run_ok), .stop_by_method_out(stop_pulse), .not_enabled_indication_out(not_enabled_indication),
    .timer_in_out(timer_fwd), .out_term_out(out_term), .sel_out(sel_now));

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic chk(string what, logic [63:0] got, logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Move one contact; the bank adds a cycle before the design sees it
  task automatic put(int t, logic [7:0] code, logic closed);
    want_code[t*CODE_W +: CODE_W] <= code;
    want_closed[t] <= closed;
    tick(3);
  endtask
  // Watch a short window for a one-cycle pulse
  task automatic catch_pulse(ref logic sig);
    seen = 1'h0;
    repeat (6) begin
      @(posedge clk_sys_in);
      if (sig === 1'h1) seen = 1'h1;
    end
  endtask
  task automatic write_sel(logic [23:0] v);
    sel_data <= v;
    sel_we <= 1'h1;
    tick(1);
    sel_we <= 1'h0;
    tick(3);
  endtask

  task automatic t_pid();
    for (int k = 0; k < 4; k++) begin
      put(2, IN_PID_I_RESET + k, 1'h1);
      chk("pid", {pid_zero, pid_freeze, pid_bypass, pid_alt}, 4'h8 >> k);
      put(2, IN_PID_I_RESET + k, 1'h0);
      chk("pid_open", {pid_zero, pid_freeze, pid_bypass, pid_alt}, 4'h0);
    end
    put(2, 8'h33, 1'h1);
    chk("retained", {pid_zero, pid_freeze, pid_bypass, pid_alt, timer_fwd}, 5'h00);
    put(2, 8'h00, 1'h0);
    $display("t_pid done");
  endtask
  task automatic t_offset_keb();
    freq_cmd <= 16'h0100;
    for (int k = 0; k < 3; k++) begin
      put(4, IN_OFFSET_1 + k, 1'h1);
      chk("offset", freq_out, 16'h0100 + 16'h0010 * (k + 1));
      put(4, 8'h00, 1'h0);
    end
    freq_cmd <= 16'h0000;
    put(5, IN_KEB_NO, 1'h1);
    for (int m = 0; m < 4; m++) begin
      method <= m;
      tick(3);
      chk("keb_method", keb_meth, (m > 2) ? 2'h0 : m);
    end
    keb_nc <= 1'h1;
    put(5, IN_KEB_NO, 1'h0);
    chk("keb_nc", keb_act, 1'h1);
    put(5, IN_KEB_NO, 1'h1);
    chk("keb_nc_closed", keb_act, 1'h0);
    keb_nc <= 1'h0;
    put(5, 8'h00, 1'h0);
    $display("t_offset_keb done");
  endtask
  task automatic t_lockout();
    wr_req <= 1'h1;
    put(6, IN_LOCKOUT, 1'h0);
    chk("locked", wr_ok, 1'h0);
    is_mon <= 1'h1;
    tick(3);
    chk("monitor", wr_ok, 1'h1);
    is_mon <= 1'h0;
    put(6, IN_LOCKOUT, 1'h1);
    chk("unlocked", wr_ok, 1'h1);
    wr_req <= 1'h0;
    put(6, 8'h00, 1'h0);
    $display("t_lockout done");
  endtask
  task automatic t_hold();
    analog <= 16'h0abc;
    put(1, IN_ANALOG_HOLD, 1'h1);
    tick(HOLD_N + 4);
    chk("held", freq_out, 16'h0abc);
    analog <= 16'h0123;
    tick(3);
    chk("still_held", freq_out, 16'h0abc);
    for (int k = 0; k < 8; k++) begin
      put(3, combo[k], 1'h0);
      chk("combo", cfg_err, 1'h1);
    end
    put(3, 8'h00, 1'h0);
    chk("no_combo", cfg_err, 1'h0);
    power_loss <= 1'h1;
    tick(3);
    chk("power_loss", freq_out, 16'h0000);
    power_loss <= 1'h0;
    put(1, 8'h00, 1'h0);
    $display("t_hold done");
  endtask
  task automatic t_search_brake();
    put(7, IN_EXT_SEARCH, 1'h1);
    tick(SEARCH_N + 4);
    want_run <= 1'h1;
    catch_pulse(search);
    chk("search", seen, 1'h1);
    want_run <= 1'h0;
    put(7, 8'h00, 1'h0);
    put(0, IN_DC_BRAKE, 1'h1);
    chk("brake", brake, 1'h1);
    want_run <= 1'h1;
    tick(3);
    chk("brake_run", brake, 1'h0);
    want_run <= 1'h0;
    jog <= 1'h1;
    tick(3);
    chk("brake_jog", brake, 1'h0);
    jog <= 1'h0;
    put(0, 8'h00, 1'h0);
    $display("t_search_brake done");
  endtask
  task automatic t_enable();
    want_run <= 1'h1;
    put(6, IN_ENABLE, 1'h0);
    chk("disabled", {run_ok, not_enabled_indication}, 2'h1);
    put(6, IN_ENABLE, 1'h1);
    chk("run_early", run_ok, 1'h0);
    want_run <= 1'h0;
    tick(3);
    want_run <= 1'h1;
    tick(3);
    chk("run_cycled", {run_ok, not_enabled_indication}, 2'h2);
    want_closed[6] <= 1'h0;
    catch_pulse(stop_pulse);
    chk("stop", seen, 1'h1);
    chk("stopped", run_ok, 1'h0);
    want_run <= 1'h0;
    put(6, 8'h00, 1'h0);
    $display("t_enable done");
  endtask
  task automatic t_outputs();
    put(2, IN_TIMER, 1'h1);
    chk("timer_in", timer_fwd, 1'h1);
    timer_res <= 1'h1;
    funcs[4] <= 1'h1;
    write_sel({8'h32, 8'h68, OUT_TIMER});
    chk("sel", sel_now, 24'h32_680f);
    chk("outs_a", out_term, 3'h1);
    write_sel({8'h96, 8'h04, 8'h73});
    chk("outs_b", out_term, 3'h2);
    timer_res <= 1'h0;
    tick(3);
    chk("outs_c", out_term, 3'h3);
    put(2, 8'h00, 1'h0);
    $display("t_outputs done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    tick(12);
    rst_b_in <= 1'h1;
    tick(3);
    chk("sel_default", sel_now, {OPEN_COLL_DEFAULT, RELAY2_DEFAULT, RELAY1_DEFAULT});
    $display("t_defaults done");
    t_pid();
    t_offset_keb();
    t_lockout();
    t_hold();
    t_search_brake();
    t_enable();
    t_outputs();
    wrap_up();
  end

  // Watchdog well past the roughly 280 cycles the tests need
  initial begin
    #50000;
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
